// [design/pmr_regs.vh]
// Constants of the management register bank: register indices, field
// positions, reset values, indirect device codes and timing counts.
// Assumes it is included by its bare name from the design files.
`ifndef PMR_REGS_VH
`define PMR_REGS_VH
// Directly indexed register numbers, five bits each.
`define PMR_IDX_BASIC_CONTROL   5'h00
`define PMR_IDX_BASIC_STATUS    5'h01
`define PMR_IDX_ID_HIGH         5'h02
`define PMR_IDX_ID_LOW          5'h03
`define PMR_IDX_ADVERTISE       5'h04
`define PMR_IDX_PARTNER         5'h05
`define PMR_IDX_EXPANSION       5'h06
`define PMR_IDX_NP_TRANSMIT     5'h07
`define PMR_IDX_NP_RECEIVE      5'h08
`define PMR_IDX_IND_CONTROL     5'h0d
`define PMR_IDX_IND_DATA        5'h0e
`define PMR_IDX_POWER_TIMING    5'h10
`define PMR_IDX_MODE_CONTROL    5'h11
`define PMR_IDX_SPECIAL_MODES   5'h12
`define PMR_IDX_TEST_PATTERN    5'h18
`define PMR_IDX_TEST_CONTROL    5'h19
`define PMR_IDX_SYMBOL_ERRORS   5'h1a
`define PMR_IDX_SPECIAL_IND     5'h1b
`define PMR_IDX_CABLE_LENGTH    5'h1c
`define PMR_IDX_INT_SOURCE      5'h1d
`define PMR_IDX_INT_MASK        5'h1e
`define PMR_IDX_SPECIAL_STATUS  5'h1f
// Indirect access: device codes, function codes and register indices.
`define PMR_DEV_PCS             5'h03
`define PMR_DEV_VENDOR          5'h1e
`define PMR_FUNC_ADDRESS        2'h0
`define PMR_WAKE_MASK_FIRST     16'h8021
`define PMR_WAKE_MASK_COUNT     8
`define PMR_VND_MATCH_THRESH    16'h000b
`define PMR_VND_SHORT_THRESH    16'h000c
`define PMR_THRESH_RESET        16'h0249
// Fixed field values and write masks.
`define PMR_BASIC_STATUS_FIXED  16'h7809
`define PMR_ADVERTISE_WMASK     16'h2de0
`define PMR_ADVERTISE_SELECTOR  16'h0001
`define PMR_NP_TRANSMIT_RESET   16'h2001
`define PMR_EXPANSION_FIXED     16'h0064
// Field positions.
`define PMR_BC_SOFT_RESET       15
`define PMR_BC_LOOPBACK         14
`define PMR_BC_SPEED            13
`define PMR_BC_AN_ENABLE        12
`define PMR_BC_POWER_DOWN       11
`define PMR_BC_ISOLATE          10
`define PMR_BC_AN_RESTART       9
`define PMR_BC_DUPLEX           8
`define PMR_MC_SLEEP_ENABLE     13
`define PMR_MC_ECHO_ENABLE      9
`define PMR_MC_SCHEME_SELECT    6
`define PMR_MC_ENERGY           1
// Frame opcodes.
`define PMR_OP_WRITE            2'h1
`define PMR_OP_READ             2'h2
`define PMR_PREAMBLE_ONES       6'h20
// Silence time before line energy is reported lost.
`define PMR_QUIET_MS            256
`define PMR_CLK_KHZ             10000
// Equals QUIET_MS times CLK_KHZ, sized to the 22-bit silence counter.
`define PMR_QUIET_CYCLES        22'h271000
`endif

// [design/pmr_register_map.v]
// Management register bank of a 10/100 transceiver, reached over the
// clause 22 management serial port (clock and bidirectional data pin).
// Assumes mdc is far slower than clk (at most clk/6) and that status
// and event inputs come from logic on clk; event inputs are pulses.
`timescale 1ns/1ps
`include "pmr_regs.vh"

module pmr_register_map #(
	parameter [15:0] ID_HIGH      = 16'h0a5a,           // Arbitrary value.
	parameter [5:0]  ID_MODEL     = 6'h15,              // Arbitrary value.
	parameter [3:0]  ID_REVISION  = 4'h1,               // Arbitrary value.
	parameter [21:0] QUIET_CYCLES = `PMR_QUIET_CYCLES
) (
	input  wire        clk,
	input  wire        reset,
	input  wire        mdc,
	input  wire        mdio_in,
	output reg         mdio_out,
	output reg         mdio_oe_n,
	input  wire [2:0]  mode_strap,
	input  wire        station_address_strap,
	input  wire        link_up,
	input  wire        an_complete,
	input  wire        energy_detected,
	input  wire        pd_fault_event,
	input  wire        page_received_event,
	input  wire        partner_np_able,
	input  wire        partner_an_able,
	input  wire [15:0] partner_ability_in,
	input  wire [15:0] next_page_rx_in,
	input  wire [15:0] int_event,
	output reg         loopback,
	output reg         speed_select,
	output reg         an_enable,
	output reg         power_down,
	output reg         isolate,
	output reg         an_restart,
	output reg         full_duplex,
	output reg         energy_sleep_enable,
	output reg         line_echo_enable,
	output reg         interrupt_scheme_select,
	output reg         line_energy_present
);
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_START = 3'h1;
	localparam [2:0] ST_OP = 3'h2;
	localparam [2:0] ST_ADDR = 3'h3;
	localparam [2:0] ST_TURN = 3'h4;
	localparam [2:0] ST_DATA = 3'h5;

	reg  [2:0]  mdc_sync;
	reg  [2:0]  mdio_sync;
	reg         mdc_level;
	reg         mdio_level;
	reg         mdc_prev;
	reg  [2:0]  state;
	reg  [5:0]  ones;
	reg  [3:0]  cnt;
	reg  [1:0]  opcode;
	reg  [9:0]  addr_shift;
	reg  [15:0] write_shift;
	reg  [15:0] read_word;
	reg         hit;
	reg  [4:0]  reg_index;
	reg         wr_stb;
	reg         rd_end_stb;
	reg  [15:0] wr_word;
	reg  [15:0] expansion_latch;
	reg  [15:0] expansion_snap;
	reg  [15:0] int_flags;
	reg  [15:0] int_snap;
	reg  [15:0] int_mask;
	reg  [15:0] advertise;
	reg  [15:0] np_transmit;
	reg  [15:0] power_timing;
	reg  [15:0] test_pattern;
	reg  [15:0] test_control;
	reg  [15:0] special_ind;
	reg  [15:0] special_status;
	reg  [2:0]  mode_field;
	reg  [4:0]  station_address;
	reg  [1:0]  ind_function;
	reg  [4:0]  ind_device;
	reg  [15:0] ind_address;
	reg  [15:0] match_thresh;
	reg  [15:0] short_thresh;
	reg  [15:0] wake_mask [0:`PMR_WAKE_MASK_COUNT-1];
	reg  [21:0] quiet_count;
	reg  [15:0] read_mux;
	reg  [15:0] ind_read;
	reg         ind_mapped;
	reg  [2:0]  wake_slot;
	reg         soft_reset;
	wire        mdc_rise;
	wire        mdc_fall;
	wire        ind_wake;
	wire        ind_match;
	wire        ind_short;
	wire        ind_data_write;
	wire [15:0] wake_offset;
	wire [15:0] strap_advertise;

	// A pin level changes only once the second and third stages agree.
	always @(posedge clk) begin
		if (reset) begin
			mdc_sync   <= 3'h0;
			mdio_sync  <= 3'h7;
			mdc_level  <= 1'b0;
			mdio_level <= 1'b1;
			mdc_prev   <= 1'b0;
		end else begin
			mdc_sync  <= {mdc_sync[1:0], mdc};
			mdio_sync <= {mdio_sync[1:0], mdio_in};
			if (mdc_sync[2] == mdc_sync[1])
				mdc_level <= mdc_sync[2];
			if (mdio_sync[2] == mdio_sync[1])
				mdio_level <= mdio_sync[2];
			mdc_prev <= mdc_level;
		end
	end

	assign mdc_rise = mdc_level & ~mdc_prev;
	assign mdc_fall = ~mdc_level & mdc_prev;

	// Frame engine: bits are taken on rising mdc, read data leaves on falling mdc.
	always @(posedge clk) begin
		if (reset) begin
			state       <= ST_IDLE;
			ones        <= 6'h0;
			cnt         <= 4'h0;
			opcode      <= 2'h0;
			addr_shift  <= 10'h0;
			write_shift <= 16'h0;
			read_word   <= 16'h0;
			hit         <= 1'b0;
			reg_index   <= 5'h0;
			wr_stb      <= 1'b0;
			rd_end_stb  <= 1'b0;
			wr_word     <= 16'h0;
			mdio_out    <= 1'b1;
			mdio_oe_n   <= 1'b1;
		end else begin
			wr_stb     <= 1'b0;
			rd_end_stb <= 1'b0;
			if (mdc_rise) begin
				case (state)
				ST_IDLE: begin
					if (mdio_level) begin
						if (ones != `PMR_PREAMBLE_ONES)
							ones <= ones + 6'h1;
					end else if (ones == `PMR_PREAMBLE_ONES) begin
						state <= ST_START;
					end else begin
						ones <= 6'h0;
					end
				end
				ST_START: begin
					ones  <= 6'h0;
					cnt   <= 4'h0;
					state <= mdio_level ? ST_OP : ST_IDLE;
				end
				ST_OP: begin
					opcode <= {opcode[0], mdio_level};
					cnt    <= cnt + 4'h1;
					if (cnt == 4'h1) begin
						cnt   <= 4'h0;
						state <= ST_ADDR;
					end
				end
				ST_ADDR: begin
					addr_shift <= {addr_shift[8:0], mdio_level};
					cnt        <= cnt + 4'h1;
					if (cnt == 4'h9) begin
						cnt       <= 4'h0;
						state     <= ST_TURN;
						reg_index <= {addr_shift[3:0], mdio_level};
						hit       <= (addr_shift[8:4] == station_address) &&
						             (opcode == `PMR_OP_READ || opcode == `PMR_OP_WRITE);
					end
				end
				ST_TURN: begin
					if (cnt == 4'h0) begin
						read_word <= read_mux;
						cnt       <= 4'h1;
					end else begin
						cnt   <= 4'h0;
						state <= ST_DATA;
					end
				end
				ST_DATA: begin
					write_shift <= {write_shift[14:0], mdio_level};
					cnt         <= cnt + 4'h1;
					if (cnt == 4'hf) begin
						state      <= ST_IDLE;
						ones       <= 6'h0;
						wr_word    <= {write_shift[14:0], mdio_level};
						wr_stb     <= hit && (opcode == `PMR_OP_WRITE);
						rd_end_stb <= hit && (opcode == `PMR_OP_READ);
					end
				end
				default: begin
					state <= ST_IDLE;
				end
				endcase
			end
			// The pin is driven only during the second turnaround bit and the data.
			if (mdc_fall) begin
				if (hit && opcode == `PMR_OP_READ && state == ST_TURN && cnt == 4'h1) begin
					mdio_oe_n <= 1'b0;
					mdio_out  <= 1'b0;
				end else if (hit && opcode == `PMR_OP_READ && state == ST_DATA) begin
					mdio_oe_n <= 1'b0;
					mdio_out  <= read_word[4'hf - cnt];
				end else begin
					mdio_oe_n <= 1'b1;
					mdio_out  <= 1'b1;
				end
			end
		end
	end

	// Only devices 3 and 30 decode.
	assign ind_data_write = wr_stb && reg_index == `PMR_IDX_IND_DATA && ind_function != `PMR_FUNC_ADDRESS;
	assign wake_offset = ind_address - `PMR_WAKE_MASK_FIRST;
	assign ind_wake  = ind_device == `PMR_DEV_PCS && ind_address >= `PMR_WAKE_MASK_FIRST &&
	                   wake_offset < `PMR_WAKE_MASK_COUNT;
	// Threshold registers at 11 and 12.
	assign ind_match = ind_device == `PMR_DEV_VENDOR && ind_address == `PMR_VND_MATCH_THRESH;
	assign ind_short = ind_device == `PMR_DEV_VENDOR && ind_address == `PMR_VND_SHORT_THRESH;
	assign strap_advertise = (mode_strap == 3'h4) ? 16'h0080 : 16'h01e0;

	// Indirect read selection; unmapped indirect indices read zero.
	always @* begin
		wake_slot  = wake_offset[2:0];
		ind_mapped = ind_wake | ind_match | ind_short;
		ind_read   = 16'h0;
		if (ind_wake)
			ind_read = wake_mask[wake_slot];
		else if (ind_match)
			ind_read = match_thresh;
		else if (ind_short)
			ind_read = short_thresh;
	end

	// Direct read multiplexer; every register is 16 bits.
	always @* begin
		read_mux = 16'h0;
		case (reg_index)
		`PMR_IDX_BASIC_CONTROL:  read_mux = {1'b0, loopback, speed_select, an_enable, power_down,
		                                     isolate, an_restart, full_duplex, 8'h0};
		`PMR_IDX_BASIC_STATUS:   read_mux = `PMR_BASIC_STATUS_FIXED | {10'h0, an_complete, 2'h0, link_up, 2'h0};
		`PMR_IDX_ID_HIGH:        read_mux = ID_HIGH;
		`PMR_IDX_ID_LOW:         read_mux = {ID_HIGH[5:0], ID_MODEL, ID_REVISION};
		`PMR_IDX_ADVERTISE:      read_mux = advertise | `PMR_ADVERTISE_SELECTOR;
		`PMR_IDX_PARTNER:        read_mux = partner_ability_in;
		`PMR_IDX_EXPANSION:      read_mux = `PMR_EXPANSION_FIXED | expansion_latch |
		                                    {12'h0, partner_np_able, 2'h0, partner_an_able};
		`PMR_IDX_NP_TRANSMIT:    read_mux = np_transmit;
		`PMR_IDX_NP_RECEIVE:     read_mux = next_page_rx_in;
		// Indirect pair at 13 and 14.
		`PMR_IDX_IND_CONTROL:    read_mux = {ind_function, 9'h0, ind_device};
		`PMR_IDX_IND_DATA:       read_mux = (ind_function == `PMR_FUNC_ADDRESS) ? ind_address :
		                                    (ind_mapped ? ind_read : 16'h0);
		`PMR_IDX_POWER_TIMING:   read_mux = power_timing;
		`PMR_IDX_MODE_CONTROL:   read_mux = {2'h0, energy_sleep_enable, 3'h0, line_echo_enable, 2'h0,
		                                     interrupt_scheme_select, 4'h0, line_energy_present, 1'b0};
		`PMR_IDX_SPECIAL_MODES:  read_mux = {8'h0, mode_field, station_address};
		`PMR_IDX_TEST_PATTERN:   read_mux = test_pattern;
		`PMR_IDX_TEST_CONTROL:   read_mux = test_control;
		`PMR_IDX_SPECIAL_IND:    read_mux = special_ind;
		// Flags at 29, mask at 30.
		`PMR_IDX_INT_SOURCE:     read_mux = int_flags;
		`PMR_IDX_INT_MASK:       read_mux = int_mask;
		`PMR_IDX_SPECIAL_STATUS: read_mux = special_status;
		default:                 read_mux = 16'h0;
		endcase
	end

	// Snapshot of latched bits as they were loaded into the read word.
	always @(posedge clk) begin
		if (reset) begin
			expansion_snap <= 16'h0;
			int_snap       <= 16'h0;
		end else if (mdc_rise && state == ST_TURN && cnt == 4'h0) begin
			expansion_snap <= (reg_index == `PMR_IDX_EXPANSION) ? expansion_latch : 16'h0;
			int_snap       <= (reg_index == `PMR_IDX_INT_SOURCE) ? int_flags : 16'h0;
		end
	end

	// Latched flags: a new event wins over the clear in the same cycle.
	always @(posedge clk) begin
		if (reset) begin
			expansion_latch <= 16'h0;
			int_flags       <= 16'h0;
		end else begin
			expansion_latch <= (expansion_latch & ~(rd_end_stb && hit ? expansion_snap : 16'h0)) |
			                   {11'h0, pd_fault_event, 2'h0, page_received_event, 1'b0};
			if (wr_stb && reg_index == `PMR_IDX_INT_SOURCE)
				int_flags <= int_event;
			else
				int_flags <= (int_flags & ~(rd_end_stb ? int_snap : 16'h0)) | int_event;
		end
	end

	// Energy indicator: hardware reset or detected energy sets it; a long silence clears it.
	always @(posedge clk) begin
		if (reset) begin
			line_energy_present <= 1'b1;
			quiet_count         <= 22'h0;
		end else if (energy_detected) begin
			line_energy_present <= 1'b1;
			quiet_count         <= 22'h0;
		end else if (quiet_count == QUIET_CYCLES - 22'h1) begin
			line_energy_present <= 1'b0;
		end else begin
			quiet_count <= quiet_count + 22'h1;
		end
	end

	// Mask storage, one entry per filter byte group.
	genvar gi;
	generate
		for (gi = 0; gi < `PMR_WAKE_MASK_COUNT; gi = gi + 1) begin : g_wake
			always @(posedge clk) begin
				if (reset)
					wake_mask[gi] <= 16'h0;
				else if (ind_data_write && ind_wake && wake_slot == gi)
					wake_mask[gi] <= wr_word;
			end
		end
	endgenerate

	// Control registers; a software reset restores these but not the energy bit.
	// Straps are taken in the synchronous reset, so they must be stable by release.
	always @(posedge clk) begin
		if (reset || soft_reset) begin
			soft_reset              <= 1'b0;
			loopback                <= 1'b0;
			speed_select            <= mode_strap[2] | mode_strap[1];
			an_enable               <= mode_strap[2];
			power_down              <= 1'b0;
			isolate                 <= 1'b0;
			an_restart              <= 1'b0;
			full_duplex             <= mode_strap[0] & ~mode_strap[2];
			advertise               <= strap_advertise;
			np_transmit             <= `PMR_NP_TRANSMIT_RESET;
			power_timing            <= 16'h0;
			test_pattern            <= 16'h0;
			test_control            <= 16'h0;
			special_ind             <= 16'h0;
			special_status          <= 16'h0;
			int_mask                <= 16'h0;
			energy_sleep_enable     <= 1'b0;
			line_echo_enable        <= 1'b0;
			interrupt_scheme_select <= 1'b0;
			mode_field              <= mode_strap;
			station_address         <= {4'h0, station_address_strap};
			ind_function            <= 2'h0;
			ind_device              <= 5'h0;
			ind_address             <= 16'h0;
		end else begin
			an_restart <= 1'b0;
			if (wr_stb) begin
				case (reg_index)
				`PMR_IDX_BASIC_CONTROL: begin
					soft_reset   <= wr_word[`PMR_BC_SOFT_RESET];
					loopback     <= wr_word[`PMR_BC_LOOPBACK];
					speed_select <= wr_word[`PMR_BC_SPEED];
					an_enable    <= wr_word[`PMR_BC_AN_ENABLE];
					power_down   <= wr_word[`PMR_BC_POWER_DOWN];
					isolate      <= wr_word[`PMR_BC_ISOLATE];
					an_restart   <= wr_word[`PMR_BC_AN_RESTART];
					full_duplex  <= wr_word[`PMR_BC_DUPLEX];
				end
				`PMR_IDX_ADVERTISE:      advertise      <= wr_word & `PMR_ADVERTISE_WMASK;
				`PMR_IDX_NP_TRANSMIT:    np_transmit    <= wr_word;
				`PMR_IDX_IND_CONTROL: begin
					ind_function <= wr_word[15:14];
					ind_device   <= wr_word[4:0];
				end
				`PMR_IDX_IND_DATA: begin
					if (ind_function == `PMR_FUNC_ADDRESS)
						ind_address <= wr_word;
				end
				`PMR_IDX_POWER_TIMING:   power_timing   <= wr_word;
				`PMR_IDX_MODE_CONTROL: begin
					energy_sleep_enable     <= wr_word[`PMR_MC_SLEEP_ENABLE];
					line_echo_enable        <= wr_word[`PMR_MC_ECHO_ENABLE];
					interrupt_scheme_select <= wr_word[`PMR_MC_SCHEME_SELECT];
				end
				`PMR_IDX_SPECIAL_MODES: begin
					mode_field      <= wr_word[7:5];
					station_address <= wr_word[4:0];
				end
				`PMR_IDX_TEST_PATTERN:   test_pattern   <= wr_word;
				`PMR_IDX_TEST_CONTROL:   test_control   <= wr_word;
				`PMR_IDX_SPECIAL_IND:    special_ind    <= wr_word;
				`PMR_IDX_INT_MASK:       int_mask       <= wr_word;
				`PMR_IDX_SPECIAL_STATUS: special_status <= wr_word;
				default:                 soft_reset     <= 1'b0;
				endcase
			end
		end
	end

	// Thresholds survive software reset, since their reset state is not trusted.
	always @(posedge clk) begin
		if (reset) begin
			match_thresh <= `PMR_THRESH_RESET;
			short_thresh <= `PMR_THRESH_RESET;
		end else if (ind_data_write) begin
			if (ind_match)
				match_thresh <= {6'h0, wr_word[9:0]};
			if (ind_short)
				short_thresh <= {6'h0, wr_word[9:0]};
		end
	end
endmodule // pmr_register_map

// [dv/pmr_register_map_monitor.sv]
// Checker for the management register bank, watching its ports.
// Assumes mdc runs 16 clk per bit and the straps hold steady.
`timescale 1ns/1ps
module pmr_register_map_monitor #(
	parameter [21:0] QUIET_CYCLES = 22'h32
) (
	input wire       clk,
	input wire       reset,
	input wire       mdio_out,
	input wire       mdio_oe_n,
	input wire [2:0] mode_strap,
	input wire       energy_detected,
	input wire       loopback,
	input wire       speed_select,
	input wire       an_enable,
	input wire       power_down,
	input wire       isolate,
	input wire       an_restart,
	input wire       full_duplex,
	input wire       energy_sleep_enable,
	input wire       line_echo_enable,
	input wire       interrupt_scheme_select,
	input wire       line_energy_present
);
	reg [21:0] quiet_cnt;
	// Silent-cycle count; it saturates so a wrap cannot hide a stuck bit.
	always @(posedge clk) begin
		if (reset || energy_detected) begin
			quiet_cnt <= 22'h0;
		end else if (quiet_cnt != 22'h3fffff) begin
			quiet_cnt <= quiet_cnt + 22'h1;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// A read answer holds the line for many cycles once it starts.
	sequence s_drive_hold;
		!mdio_oe_n [*8];
	endsequence
	chk_drive_starts_low: assert property ($fell(mdio_oe_n) |-> !mdio_out ##1 s_drive_hold)
		else $error("read drive did not start low and hold");
	chk_idle_line_high: assert property (mdio_oe_n |-> mdio_out)
		else $error("data output not high while released");
	chk_energy_after_reset: assert property ($fell(reset) |-> line_energy_present)
		else $error("energy bit not set by hardware reset");
	chk_energy_goes_quiet: assert property ((quiet_cnt > QUIET_CYCLES + 22'h2) |-> !line_energy_present)
		else $error("energy bit still set after silence");
	chk_strap_defaults: assert property ($fell(reset) |-> an_enable == mode_strap[2]
		&& speed_select == (mode_strap[2] | mode_strap[1]) && full_duplex == (mode_strap[0] & ~mode_strap[2]))
		else $error("strap defaults wrong after reset");
	chk_mode_defaults: assert property ($fell(reset) |-> !energy_sleep_enable && !line_echo_enable
		&& !interrupt_scheme_select)
		else $error("mode control bits not cleared by reset");
	chk_control_defaults: assert property ($fell(reset) |-> !loopback && !isolate && !power_down && !an_restart)
		else $error("basic control bits not cleared by reset");
	chk_restart_pulse: assert property (an_restart |=> !an_restart)
		else $error("restart held longer than one cycle");
endmodule // pmr_register_map_monitor

bind pmr_register_map pmr_register_map_monitor #(.QUIET_CYCLES(QUIET_CYCLES)) i_pmr_register_map_monitor (
	.clk(clk), .reset(reset), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .mode_strap(mode_strap),
	.energy_detected(energy_detected), .loopback(loopback), .speed_select(speed_select), .an_enable(an_enable),
	.power_down(power_down), .isolate(isolate), .an_restart(an_restart), .full_duplex(full_duplex),
	.energy_sleep_enable(energy_sleep_enable), .line_echo_enable(line_echo_enable),
	.interrupt_scheme_select(interrupt_scheme_select), .line_energy_present(line_energy_present));

// [dv/pmr_station_model.sv]
// Station management controller model that sends serial port frames.
// Assumes the bench resolves the shared data line with a pull-up.
`timescale 1ns/1ps
`include "pmr_regs.vh"
module pmr_station_model (
	input wire clk,
	input wire mdio,
	output reg mdc,
	output reg host_oe,
	output reg host_bit
);
	// Idle: the clock stands still and the line is released.
	initial begin
		mdc = 1'b0;
		host_oe = 1'b0;
		host_bit = 1'b1;
	end
	// One frame at station address 1; each bit is eight clk low, eight high.
	task xfer(input [1:0] op, input [4:0] ra, input [15:0] wd, output [15:0] rd);
		reg [63:0] f;
		integer i;
		begin
			f = {32'hffffffff, 2'h1, op, 5'h01, ra, 2'h2, wd};
			rd = 16'h0000;
			for (i = 63; i >= 0; i = i - 1) begin
				mdc <= 1'b0;
				host_oe <= !(op == `PMR_OP_READ && i < 18); // Released from turnaround on.
				host_bit <= f[i];
				repeat (8) @(posedge clk);
				mdc <= 1'b1;
				repeat (8) @(posedge clk);
				if (i < 16) rd[i] = mdio;
			end
			// Close the last bit low, so the device sees a falling edge and lets go of the line.
			mdc <= 1'b0;
			host_oe <= 1'b0;
			repeat (8) @(posedge clk);
		end
	endtask
endmodule // pmr_station_model

// [dv/pmr_register_map_test.sv]
// Self-checking bench for the management register bank.
// Assumes the station model makes every frame; the line has a pull-up.
`timescale 1ns/1ps
`include "pmr_regs.vh"
module pmr_register_map_test;
	reg        clk, reset, energy, pd_ev, pg_ev, np_able, an_able, link, an_done;
	reg [15:0] int_ev, ability, np_rx;
	reg [2:0]  strap;
	wire       mdc, host_oe, host_bit, mdio_out, mdio_oe_n, mdio_line;
	wire       loopback, speed_select, an_enable, power_down, isolate, an_restart, full_duplex;
	wire       energy_sleep_enable, line_echo_enable, interrupt_scheme_select, line_energy_present;
	integer    miscompares, n_tests;
	// Pull-up wins whenever nobody drives the line.
	assign mdio_line = !mdio_oe_n ? mdio_out : (host_oe ? host_bit : 1'b1);
	// Identifier values are arbitrary.
	pmr_register_map #(.ID_HIGH(16'h1234), .ID_MODEL(6'h2a), .ID_REVISION(4'h9), .QUIET_CYCLES(22'h32))
	i_pmr_register_map (
		.clk(clk), .reset(reset), .mdc(mdc), .mdio_in(mdio_line), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n),
		.mode_strap(strap), .station_address_strap(1'b1), .link_up(link), .an_complete(an_done),
		.energy_detected(energy), .pd_fault_event(pd_ev), .page_received_event(pg_ev),
		.partner_np_able(np_able), .partner_an_able(an_able), .partner_ability_in(ability),
		.next_page_rx_in(np_rx), .int_event(int_ev), .loopback(loopback), .speed_select(speed_select),
		.an_enable(an_enable), .power_down(power_down), .isolate(isolate), .an_restart(an_restart),
		.full_duplex(full_duplex), .energy_sleep_enable(energy_sleep_enable), .line_echo_enable(line_echo_enable),
		.interrupt_scheme_select(interrupt_scheme_select), .line_energy_present(line_energy_present));
	pmr_station_model i_pmr_station_model (
		.clk(clk), .mdio(mdio_line), .mdc(mdc), .host_oe(host_oe), .host_bit(host_bit));
	// Clock of 100 ns.
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task print_verdict;
		begin
			$display("comparisons %0d mismatches %0d", n_tests, miscompares);
			if (miscompares == 0 && n_tests > 0) $display("No errors found");
			else $display("Errors were found");
			$finish;
		end
	endtask
	task cmp(input [15:0] g, input [15:0] e);
		begin
			n_tests = n_tests + 1;
			if (g !== e) begin
				miscompares = miscompares + 1;
				$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
			end
		end
	endtask
	task wr(input [4:0] ra, input [15:0] d);
		reg [15:0] x;
		i_pmr_station_model.xfer(`PMR_OP_WRITE, ra, d, x);
	endtask
	task rd(input [4:0] ra, input [15:0] e);
		reg [15:0] d;
		begin
			i_pmr_station_model.xfer(`PMR_OP_READ, ra, 16'h0000, d);
			cmp(d, e);
		end
	endtask
	// Select device, set index, switch to data, then access.
	task ind(input [4:0] dev, input [15:0] idx, input w, input [15:0] d, input [15:0] e);
		begin
			wr(5'h0d, {11'h000, dev});
			wr(5'h0e, idx);
			wr(5'h0d, {2'h1, 9'h000, dev});
			if (w) wr(5'h0e, d);
			rd(5'h0e, e);
		end
	endtask
	task t_status;
		begin
			rd(5'h01, 16'h782d);
			rd(5'h05, 16'h1234);
			rd(5'h08, 16'h5678);
			rd(5'h02, 16'h1234);
			rd(5'h03, 16'hd2a9);
			$display("test status done");
		end
	endtask
	task t_expansion;
		begin
			@(posedge clk);
			{pd_ev, pg_ev, np_able, an_able, int_ev} <= {4'hf, 16'h0005};
			@(posedge clk);
			{pd_ev, pg_ev, int_ev} <= 18'h00000;
			rd(5'h06, 16'h007f);
			rd(5'h06, 16'h006d);
			rd(5'h1d, 16'h0005);
			rd(5'h1d, 16'h0000);
			int_ev <= 16'h8001;
			@(posedge clk);
			int_ev <= 16'h0000;
			wr(5'h1d, 16'h0000);
			rd(5'h1d, 16'h0000);
			$display("test expansion done");
		end
	endtask
	task t_mode;
		begin
			wr(5'h00, 16'h0400);
			wr(5'h11, 16'hffff);
			rd(5'h11, 16'h2242);
			cmp({12'h000, isolate, energy_sleep_enable, line_echo_enable, interrupt_scheme_select}, 16'h000f);
			wr(5'h11, 16'h0000);
			wr(5'h09, 16'hffff);
			rd(5'h09, 16'h0000);
			rd(5'h12, 16'h00e1);
			$display("test mode done");
		end
	endtask
	task t_indirect;
		begin
			ind(5'h03, 16'h8021, 1'b1, 16'hbeef, 16'hbeef);
			ind(5'h03, 16'h8028, 1'b1, 16'h1234, 16'h1234);
			ind(5'h03, 16'h8021, 1'b0, 16'h0000, 16'hbeef);
			ind(5'h1e, 16'h000b, 1'b0, 16'h0000, 16'h0249);
			ind(5'h1e, 16'h000c, 1'b1, 16'hffff, 16'h03ff);
			ind(5'h05, 16'h8021, 1'b0, 16'h0000, 16'h0000);
			$display("test indirect done");
		end
	endtask
	task t_energy;
		begin
			energy <= 1'b0;
			repeat (60) @(posedge clk);
			rd(5'h11, 16'h0000);
			wr(5'h00, 16'h0300);
			wr(5'h00, 16'h8000);
			rd(5'h00, 16'h3000);
			rd(5'h04, 16'h01e1);
			rd(5'h11, 16'h0000);
			energy <= 1'b1;
			strap <= 3'h4;
			reset <= 1'b1;
			repeat (3) @(posedge clk);
			reset <= 1'b0;
			repeat (4) @(posedge clk);
			rd(5'h11, 16'h0002);
			rd(5'h04, 16'h0081);
			rd(5'h12, 16'h0081);
			$display("test energy done");
		end
	endtask
	// Cuts a hung run short.
	initial begin
		repeat (80000) @(posedge clk);
		miscompares = miscompares + 1;
		print_verdict;
	end
	// Reset, then the scenarios in turn.
	initial begin
		miscompares = 0;
		n_tests = 0;
		{reset, energy, link, an_done} = 4'hf;
		strap = 3'h7;
		{pd_ev, pg_ev, np_able, an_able, int_ev} = 20'h00000;
		ability = 16'h1234;
		np_rx = 16'h5678;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		repeat (4) @(posedge clk);
		t_status;
		t_expansion;
		t_mode;
		t_indirect;
		t_energy;
		print_verdict;
	end
endmodule // pmr_register_map_test
